// *** common/pmc_pkg.sv ***
// Constants, register layout and state type of the power mode controller
package pmc_pkg;

    // ************************************************************
    // Clock rates and derived counts
    // ************************************************************
    localparam int          CLK_HZ            = 50_000_000;
    localparam int          LF_CLK_HZ         = 32_768;
    localparam int          LF_DIV_CYCLES     = CLK_HZ / LF_CLK_HZ;
    localparam int          MS_PER_S          = 1000;
    localparam int          SOFT_RESET_CYCLES = 16;
    localparam int          TIMER_W           = 16;

    // ************************************************************
    // Register offsets and reset values
    // ************************************************************
    localparam logic [7:0]  SYS_CTRL_ADDR       = 8'h02;
    localparam logic [7:0]  SYS_CTRL_TWO_ADDR   = 8'h03;
    localparam logic [7:0]  SYS_CTRL_RESET      = 8'h0B;
    localparam logic [7:0]  SYS_CTRL_TWO_RESET  = 8'h00;
    localparam logic [7:0]  SYS_CTRL_TWO_MASK   = 8'h1F;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int          SC_SOFT_RESET_BIT   = 7;
    localparam int          SC_EXT_CLK_BIT      = 6;
    localparam int          SC_HIBERNATE_BIT    = 5;
    localparam int          SC_SLEEP_BIT        = 4;
    localparam int          SC_GPIO_EN_BIT      = 3;
    localparam int          SC_KEYPAD_EN_BIT    = 1;
    localparam int          SC_PWM_EN_BIT       = 0;
    localparam int          SC2_IO_OFF_BIT      = 4;
    localparam int          SC2_AUTO_SLEEP_BIT  = 3;
    localparam int          SC2_DELAY_MSB       = 2;
    localparam int          SC2_DELAY_LSB       = 0;

    // ************************************************************
    // Power mode codes shown on the mode output
    // ************************************************************
    localparam logic [1:0]  MODE_OPERATIONAL    = 2'h0;
    localparam logic [1:0]  MODE_SLEEP          = 2'h1;
    localparam logic [1:0]  MODE_HIBERNATE      = 2'h2;
    localparam logic [1:0]  MODE_WAKING         = 2'h3;

    typedef enum logic [2:0] {
        PMC_OPERATIONAL,
        PMC_WAKING,
        PMC_SLEEP,
        PMC_KEY_DEBOUNCE,
        PMC_HIBERNATE
    } pmc_state_t;

    // Auto-sleep delay in milliseconds per select code
    function automatic int sleep_delay_ms(input logic [2:0] sel);
        case (sel)
            3'h0:    sleep_delay_ms = 4;
            3'h1:    sleep_delay_ms = 16;
            3'h2:    sleep_delay_ms = 32;
            3'h3:    sleep_delay_ms = 64;
            3'h4:    sleep_delay_ms = 128;
            3'h5:    sleep_delay_ms = 256;
            3'h6:    sleep_delay_ms = 512;
            default: sleep_delay_ms = 1024;
        endcase
    endfunction

    // Delay in low-frequency ticks, rounded down
    function automatic logic [TIMER_W-1:0] sleep_delay_ticks(input logic [2:0] sel);
        sleep_delay_ticks = TIMER_W'((sleep_delay_ms(sel) * LF_CLK_HZ) / MS_PER_S);
    endfunction

endpackage

// *** rtl/pmc_tick_timer.sv ***
// Loadable down-counter stepped by low-frequency tick enables
`timescale 1ns/1ps
module pmc_tick_timer #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             load_in,
    input  wire logic [WIDTH-1:0] load_value_in,
    input  wire logic             clear_in,
    input  wire logic             tick_in,
    output logic                  running_out,
    output logic                  expired_out
);

    logic [WIDTH-1:0] count;

    // ************************************************************
    // Count down one step per tick, pulse on reaching the end
    // ************************************************************
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count       <= '0;
            running_out <= 1'b0;
            expired_out <= 1'b0;
        end else begin
            expired_out <= 1'b0;
            if (load_in) begin
                count       <= load_value_in;
                running_out <= 1'b1;
            end else if (clear_in) begin
                running_out <= 1'b0;
            end else if (running_out && tick_in) begin
                if (count <= WIDTH'(1)) begin
                    running_out <= 1'b0;
                    expired_out <= 1'b1;
                end else begin
                    count <= count - WIDTH'(1);
                end
            end
        end
    end

endmodule // pmc_tick_timer

// *** rtl/pmc_power_mode_controller.sv ***
// Power mode controller: modes, auto-sleep, wakeup, clock gating and reset merge
`timescale 1ns/1ps
module pmc_power_mode_controller
    import pmc_pkg::*;
#(
    parameter int DEBOUNCE_TICKS = 16
) (
    input  wire logic       ref_clk_in,
    input  wire logic       reset_n_in,
    input  wire logic       lvd_reset_in,
    input  wire logic       ext_clk_32k_in,
    input  wire logic       rc_ready_in,
    input  wire logic       wakeup_pin_in,
    input  wire logic       keypress_in,
    input  wire logic       hotkey_in,
    input  wire logic       irq_event_in,
    input  wire logic       i2c_addr_wr_match_in,
    input  wire logic       i2c_own_xfer_done_in,
    input  wire logic       i2c_reset_req_in,
    input  wire logic       reg_wr_en_in,
    input  wire logic       reg_rd_en_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wr_data_in,
    output logic      [7:0] reg_rd_data_out,
    output logic            sys_reset_n_out,
    output logic            rc_osc_en_out,
    output logic            lf_osc_en_out,
    output logic            ext_clk_sel_out,
    output logic            lf_tick_out,
    output logic            keypad_clk_en_out,
    output logic            pwm_clk_en_out,
    output logic            gpio_clk_en_out,
    output logic            io_shifter_off_out,
    output logic            i2c_active_out,
    output logic            scl_hold_out,
    output logic      [1:0] power_mode_out
);

    // ************************************************************
    // Declarations
    // ************************************************************
    localparam int          PIN_W = 6;
    localparam int          DIV_W = $clog2(LF_DIV_CYCLES + 1);

    logic [1:0]             rst_sync;
    logic                   rst_n;
    logic [PIN_W-1:0]       pin_meta;
    logic [PIN_W-1:0]       pin_sync;
    logic                   lvd_s;
    logic                   ext_clk_s;
    logic                   rc_ready_s;
    logic                   wakeup_s;
    logic                   keypress_s;
    logic                   hotkey_s;
    logic                   ext_clk_prev;
    logic [DIV_W-1:0]       div_count;
    logic                   div_tick;
    logic                   lf_tick;
    logic [7:0]             sys_ctrl;
    logic [7:0]             sys_ctrl_two;
    logic [$clog2(SOFT_RESET_CYCLES+1)-1:0] soft_count;
    logic                   soft_done;
    logic                   sync_reset;
    pmc_state_t             state;
    pmc_state_t             next_state;
    logic                   wake_event;
    logic                   auto_expired;
    logic                   auto_load;
    logic                   auto_clear;
    logic                   deb_expired;
    logic                   deb_load;
    logic                   sc_wr;
    logic                   sc2_wr;

    // ************************************************************
    // Reset release and pin synchronisers
    // ************************************************************

    // Two-stage release of the external reset
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    assign rst_n = rst_sync[1];

    // Two flip-flops on every asynchronous input
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= {lvd_reset_in, ext_clk_32k_in, rc_ready_in, wakeup_pin_in, keypress_in, hotkey_in};
            pin_sync <= pin_meta;
        end
    end

    assign {lvd_s, ext_clk_s, rc_ready_s, wakeup_s, keypress_s, hotkey_s} = pin_sync;

    // ************************************************************
    // Low-frequency tick: internal divider or external clock edge
    // ************************************************************

    // Divider standing in for the RC-derived 32 kHz clock
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            div_count    <= '0;
            div_tick     <= 1'b0;
            ext_clk_prev <= 1'b0;
        end else begin
            ext_clk_prev <= ext_clk_s;
            div_tick     <= (div_count == DIV_W'(LF_DIV_CYCLES - 1));
            if (div_count == DIV_W'(LF_DIV_CYCLES - 1)) begin
                div_count <= '0;
            end else begin
                div_count <= div_count + DIV_W'(1);
            end
        end
    end

    // Source choice; no ticks while the slow oscillator is off
    always_comb begin
        if (state == PMC_HIBERNATE) begin
            lf_tick = 1'b0;
        end else if (sys_ctrl[SC_EXT_CLK_BIT]) begin
            lf_tick = ext_clk_s & ~ext_clk_prev;
        end else begin
            lf_tick = div_tick;
        end
    end

    // ************************************************************
    // Reset sources and soft reset sequencing
    // ************************************************************

    // Soft reset runs a fixed number of cycles, then reloads registers
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            soft_count <= '0;
            soft_done  <= 1'b0;
        end else begin
            soft_done <= 1'b0;
            if (!sys_ctrl[SC_SOFT_RESET_BIT] || soft_done) begin
                soft_count <= '0;
            end else if (soft_count == $bits(soft_count)'(SOFT_RESET_CYCLES - 1)) begin
                soft_done  <= 1'b1;
                soft_count <= '0;
            end else begin
                soft_count <= soft_count + $bits(soft_count)'(1);
            end
        end
    end

    assign sync_reset = lvd_s | i2c_reset_req_in | soft_done;

    // ************************************************************
    // Register writes
    // ************************************************************
    assign sc_wr  = reg_wr_en_in && (reg_addr_in == SYS_CTRL_ADDR);
    assign sc2_wr = reg_wr_en_in && (reg_addr_in == SYS_CTRL_TWO_ADDR);

    // System control: a write wins over the hardware clears
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            sys_ctrl <= SYS_CTRL_RESET;
        end else if (sync_reset) begin
            sys_ctrl <= SYS_CTRL_RESET;
        end else if (sc_wr) begin
            sys_ctrl <= reg_wr_data_in;
        end else begin
            if (next_state == PMC_SLEEP && state != PMC_SLEEP) begin
                sys_ctrl[SC_SLEEP_BIT] <= 1'b0;
            end
            if (next_state == PMC_WAKING || (state == PMC_KEY_DEBOUNCE && next_state == PMC_SLEEP)) begin
                sys_ctrl[SC_HIBERNATE_BIT] <= 1'b0;
            end
        end
    end

    // System control two: supply and auto-sleep settings
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            sys_ctrl_two <= SYS_CTRL_TWO_RESET;
        end else if (sync_reset) begin
            sys_ctrl_two <= SYS_CTRL_TWO_RESET;
        end else if (sc2_wr) begin
            sys_ctrl_two <= reg_wr_data_in & SYS_CTRL_TWO_MASK;
        end
    end

    // Registered read port, unmapped offsets read zero
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            reg_rd_data_out <= 8'h00;
        end else if (reg_rd_en_in) begin
            case (reg_addr_in)
                SYS_CTRL_ADDR:     reg_rd_data_out <= sys_ctrl;
                SYS_CTRL_TWO_ADDR: reg_rd_data_out <= sys_ctrl_two;
                default:           reg_rd_data_out <= 8'h00;
            endcase
        end
    end

    // ************************************************************
    // Auto-sleep and key debounce timers
    // ************************************************************
    assign auto_load  = (state == PMC_OPERATIONAL) && sys_ctrl_two[SC2_AUTO_SLEEP_BIT]
                        && i2c_own_xfer_done_in;
    assign auto_clear = (state != PMC_OPERATIONAL) || !sys_ctrl_two[SC2_AUTO_SLEEP_BIT]
                        || i2c_addr_wr_match_in;
    assign deb_load   = (state == PMC_HIBERNATE) && keypress_s;

    // Auto-sleep inactivity timeout on slow ticks
    pmc_tick_timer #(
        .WIDTH          (TIMER_W)
    ) u_auto_sleep_timer (
        .clk_in         (ref_clk_in),
        .rst_n_in       (rst_n),
        .load_in        (auto_load),
        .load_value_in  (sleep_delay_ticks(sys_ctrl_two[SC2_DELAY_MSB:SC2_DELAY_LSB])),
        .clear_in       (auto_clear),
        .tick_in        (lf_tick),
        .running_out    (),
        .expired_out    (auto_expired)
    );

    // Key debounce on slow ticks
    pmc_tick_timer #(
        .WIDTH          (TIMER_W)
    ) u_debounce_timer (
        .clk_in         (ref_clk_in),
        .rst_n_in       (rst_n),
        .load_in        (deb_load),
        .load_value_in  (TIMER_W'(DEBOUNCE_TICKS)),
        .clear_in       (state != PMC_KEY_DEBOUNCE),
        .tick_in        (lf_tick),
        .running_out    (),
        .expired_out    (deb_expired)
    );

    // ************************************************************
    // Mode state machine
    // ************************************************************
    assign wake_event = i2c_addr_wr_match_in | wakeup_s | hotkey_s | irq_event_in;

    // Next mode
    always_comb begin
        next_state = state;
        case (state)
            PMC_OPERATIONAL: begin
                if (sys_ctrl[SC_HIBERNATE_BIT]) begin
                    next_state = PMC_HIBERNATE;
                end else if (sys_ctrl[SC_SLEEP_BIT]) begin
                    next_state = PMC_SLEEP;
                end else if (auto_expired && sys_ctrl_two[SC2_AUTO_SLEEP_BIT]) begin
                    next_state = PMC_SLEEP;
                end
            end
            PMC_SLEEP: begin
                if (wake_event) begin
                    next_state = PMC_WAKING;
                end
            end
            PMC_WAKING: begin
                if (rc_ready_s) begin
                    next_state = PMC_OPERATIONAL;
                end
            end
            PMC_HIBERNATE: begin
                if (i2c_addr_wr_match_in) begin
                    next_state = PMC_WAKING;
                end else if (keypress_s) begin
                    next_state = PMC_KEY_DEBOUNCE;
                end
            end
            PMC_KEY_DEBOUNCE: begin
                if (i2c_addr_wr_match_in) begin
                    next_state = PMC_WAKING;
                end else if (!keypress_s) begin
                    next_state = PMC_HIBERNATE;
                end else if (deb_expired) begin
                    next_state = PMC_SLEEP;
                end
            end
            default: begin
                next_state = PMC_OPERATIONAL;
            end
        endcase
    end

    // Mode register; any merged reset returns to operational
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state <= PMC_OPERATIONAL;
        end else if (sync_reset) begin
            state <= PMC_OPERATIONAL;
        end else begin
            state <= next_state;
        end
    end

    // ************************************************************
    // Registered outputs
    // ************************************************************

    // Mode, oscillator and handshake outputs follow the next mode
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            rc_osc_en_out     <= 1'b1;
            lf_osc_en_out     <= 1'b1;
            scl_hold_out      <= 1'b0;
            i2c_active_out    <= 1'b1;
            power_mode_out    <= MODE_OPERATIONAL;
        end else begin
            rc_osc_en_out  <= (next_state == PMC_OPERATIONAL) || (next_state == PMC_WAKING);
            lf_osc_en_out  <= (next_state != PMC_HIBERNATE);
            scl_hold_out   <= (next_state == PMC_WAKING);
            i2c_active_out <= (next_state == PMC_OPERATIONAL);
            case (next_state)
                PMC_OPERATIONAL:  power_mode_out <= MODE_OPERATIONAL;
                PMC_WAKING:       power_mode_out <= MODE_WAKING;
                PMC_HIBERNATE:    power_mode_out <= MODE_HIBERNATE;
                default:          power_mode_out <= MODE_SLEEP;
            endcase
        end
    end

    // Module clock gates, slow tick, supply and reset outputs
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            keypad_clk_en_out  <= 1'b0;
            pwm_clk_en_out     <= 1'b0;
            gpio_clk_en_out    <= 1'b0;
            ext_clk_sel_out    <= 1'b0;
            lf_tick_out        <= 1'b0;
            io_shifter_off_out <= 1'b0;
            sys_reset_n_out    <= 1'b0;
        end else begin
            keypad_clk_en_out  <= (state == PMC_KEY_DEBOUNCE)
                                  || ((state != PMC_HIBERNATE) && sys_ctrl[SC_KEYPAD_EN_BIT]);
            pwm_clk_en_out     <= (state != PMC_HIBERNATE) && sys_ctrl[SC_PWM_EN_BIT];
            gpio_clk_en_out    <= (state != PMC_HIBERNATE) && sys_ctrl[SC_GPIO_EN_BIT];
            ext_clk_sel_out    <= sys_ctrl[SC_EXT_CLK_BIT];
            lf_tick_out        <= lf_tick;
            io_shifter_off_out <= sys_ctrl_two[SC2_IO_OFF_BIT];
            sys_reset_n_out    <= ~(sync_reset | sys_ctrl[SC_SOFT_RESET_BIT]);
        end
    end

endmodule // pmc_power_mode_controller

// *** tb/pmc_checker.sv ***
// Port-level checks of the power mode controller
`timescale 1ns/1ps
module pmc_checker
    import pmc_pkg::*;
(
    input wire logic       ref_clk_in, reset_n_in,
    input wire logic       reg_wr_en_in, i2c_addr_wr_match_in,
    input wire logic [7:0] reg_addr_in, reg_wr_data_in,
    input wire logic       sys_reset_n_out, rc_osc_en_out,
    input wire logic       lf_osc_en_out, i2c_active_out,
    input wire logic       scl_hold_out,
    input wire logic [1:0] power_mode_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    logic       ctl_wr;
    logic [1:0] m;
    // Control register write strobe and mode alias
    assign ctl_wr = reg_wr_en_in && reg_addr_in == SYS_CTRL_ADDR;
    assign m = power_mode_out;
    a_sleep_rc_off: assert property (m == MODE_SLEEP |-> !rc_osc_en_out)
        else $error("rc oscillator on in sleep");
    a_hib_lf_off: assert property (m == MODE_HIBERNATE |-> !lf_osc_en_out)
        else $error("slow oscillator on in hibernate");
    a_scl_hold_wake: assert property (scl_hold_out |-> m == MODE_WAKING)
        else $error("scl held outside waking");
    a_waking_outputs: assert property (m == MODE_WAKING |-> scl_hold_out && rc_osc_en_out)
        else $error("waking without scl hold or rc");
    a_i2c_full_op: assert property (i2c_active_out |-> m == MODE_OPERATIONAL)
        else $error("i2c active outside operational");
    a_sleep_write: assert property (ctl_wr && reg_wr_data_in[7:4] == 4'h1 && m == MODE_OPERATIONAL
        |-> ##2 m == MODE_SLEEP) else $error("sleep write not obeyed");
    a_hib_write: assert property (ctl_wr && reg_wr_data_in[7:4] == 4'h2 && m == MODE_OPERATIONAL
        |-> ##2 m == MODE_HIBERNATE) else $error("hibernate write not obeyed");
    a_wake_match: assert property ((m == MODE_SLEEP || m == MODE_HIBERNATE) && i2c_addr_wr_match_in
        |=> m == MODE_WAKING) else $error("address match did not wake");
    a_soft_reset: assert property (ctl_wr && reg_wr_data_in[7]
        |-> ##[1:2] !sys_reset_n_out ##[1:30] sys_reset_n_out) else $error("soft reset pulse wrong");
    c_sleep: cover property (m == MODE_SLEEP);
    c_hib: cover property (m == MODE_HIBERNATE);
    c_soft: cover property ($fell(sys_reset_n_out));
endmodule // pmc_checker

// *** tb/pmc_host_model.sv ***
// Host model: register cycles and own-address I2C traffic
`timescale 1ns/1ps
module pmc_host_model (
    input  wire logic       clk_in,
    input  wire logic [7:0] rd_data_in,
    output logic            wr_out, rd_out, match_out, done_out,
    output logic      [7:0] addr_out, data_out
);
    initial {wr_out, rd_out, match_out, done_out, addr_out, data_out} = 20'h00000;
    // Write one byte; released bus shows inverted values
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        {wr_out, addr_out, data_out} <= {1'b1, a, d};
        @(posedge clk_in);
        {wr_out, addr_out, data_out} <= {1'b0, ~a, ~d};
    endtask
    // Read one byte, taken once it has settled
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        {rd_out, addr_out} <= {1'b1, a};
        @(posedge clk_in);
        {rd_out, addr_out} <= {1'b0, ~a};
        @(negedge clk_in);
        d = rd_data_in;
    endtask
    // Own address with write direction, then transfer end
    task automatic xfer();
        @(posedge clk_in);
        match_out <= 1'b1;
        @(posedge clk_in);
        match_out <= 1'b0;
        repeat (8) @(posedge clk_in);
        done_out <= 1'b1;
        @(posedge clk_in);
        done_out <= 1'b0;
    endtask
endmodule // pmc_host_model

// *** tb/power_mode_controller_bench.sv ***
// Self-checking bench of the power mode controller
`timescale 1ns/1ps
module power_mode_controller_bench;
    import pmc_pkg::*;
    logic ref_clk_in, reset_n_in, lvd_reset_in, ext_clk_32k_in, rc_ready_in, wakeup_pin_in, keypress_in;
    logic hotkey_in, irq_event_in, i2c_addr_wr_match_in, i2c_own_xfer_done_in, i2c_reset_req_in;
    logic reg_wr_en_in, reg_rd_en_in, sys_reset_n_out, rc_osc_en_out, lf_osc_en_out, ext_clk_sel_out;
    logic lf_tick_out, keypad_clk_en_out, pwm_clk_en_out, gpio_clk_en_out, io_shifter_off_out;
    logic i2c_active_out, scl_hold_out;
    logic [7:0] reg_addr_in, reg_wr_data_in, reg_rd_data_out, v;
    logic [1:0] power_mode_out;
    int         num_errors, cmp_count, cyc;
    pmc_power_mode_controller #(.DEBOUNCE_TICKS(2)) dut_u (.*);
    pmc_host_model h_u (.clk_in(ref_clk_in), .rd_data_in(reg_rd_data_out), .wr_out(reg_wr_en_in),
        .rd_out(reg_rd_en_in), .match_out(i2c_addr_wr_match_in), .done_out(i2c_own_xfer_done_in),
        .addr_out(reg_addr_in), .data_out(reg_wr_data_in));
    initial begin
        ref_clk_in = 1'b0;
        forever #10 ref_clk_in = ~ref_clk_in;
    end
    // Fast external slow clock, 8 system cycles a period
    initial begin
        ext_clk_32k_in = 1'b0;
        forever #80 ext_clk_32k_in = ~ext_clk_32k_in;
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wm(input logic [1:0] m);
        int n;
        n = 0;
        while (power_mode_out !== m && n < 4000) begin
            @(negedge ref_clk_in);
            n++;
        end
        chk("mode", {6'h00, m}, {6'h00, power_mode_out});
    endtask
    // Wake from low power: 0 I2C, 1 pin, 2 hotkey, 3 interrupt event
    task automatic wake(input int src);
        if (src == 0) h_u.xfer();
        else begin
            @(posedge ref_clk_in);
            {irq_event_in, hotkey_in, wakeup_pin_in} <= 3'(1 << (src - 1));
            repeat (4) @(posedge ref_clk_in);
            {irq_event_in, hotkey_in, wakeup_pin_in} <= 3'h0;
        end
        wm(MODE_WAKING);
        chk("scl hold", 8'h01, {7'h00, scl_hold_out});
        @(posedge ref_clk_in);
        rc_ready_in <= 1'b1;
        wm(MODE_OPERATIONAL);
        chk("scl release", 8'h00, {7'h00, scl_hold_out});
        @(posedge ref_clk_in);
        rc_ready_in <= 1'b0;
    endtask
    task automatic t_regs();
        h_u.rd(SYS_CTRL_ADDR, v);
        chk("ctrl reset", 8'h0B, v);
        chk("ext sel", 8'h00, {7'h00, ext_clk_sel_out});
        h_u.wr(SYS_CTRL_TWO_ADDR, 8'hF7);
        h_u.rd(SYS_CTRL_TWO_ADDR, v);
        chk("ctrl two", 8'h17, v);
        chk("io off", 8'h01, {7'h00, io_shifter_off_out});
        h_u.wr(SYS_CTRL_TWO_ADDR, 8'h00);
        h_u.rd(8'h7F, v);
        chk("unmapped", 8'h00, v);
    endtask
    task automatic t_sleep();
        for (int s = 0; s < 4; s++) begin
            h_u.wr(SYS_CTRL_ADDR, 8'h1B);
            wm(MODE_SLEEP);
            chk("rc in sleep", 8'h00, {7'h00, rc_osc_en_out});
            wake(s);
            h_u.rd(SYS_CTRL_ADDR, v);
            chk("sleep bit", 8'h0B, v);
        end
    endtask
    task automatic t_gates();
        for (int i = 0; i < 4; i++) begin
            v = (i == 3) ? 8'h08 : 8'(i);
            h_u.wr(SYS_CTRL_ADDR, v);
            repeat (3) @(negedge ref_clk_in);
            chk("gates", {5'h00, v[1], v[0], v[3]}, {5'h00, keypad_clk_en_out, pwm_clk_en_out, gpio_clk_en_out});
        end
        h_u.wr(SYS_CTRL_ADDR, 8'h0B);
    endtask
    task automatic t_hib();
        h_u.wr(SYS_CTRL_ADDR, 8'h2B);
        wm(MODE_HIBERNATE);
        chk("lf in hib", 8'h00, {7'h00, lf_osc_en_out});
        wake(0);
        // Short key press falls back to hibernate, held key stays asleep
        h_u.wr(SYS_CTRL_ADDR, 8'h6B);
        for (int p = 0; p < 2; p++) begin
            wm(MODE_HIBERNATE);
            @(posedge ref_clk_in);
            keypress_in <= 1'b1;
            wm(MODE_SLEEP);
            @(posedge ref_clk_in);
            keypress_in <= (p == 1);
        end
        repeat (60) @(negedge ref_clk_in);
        chk("key mode", {6'h00, MODE_SLEEP}, {6'h00, power_mode_out});
        h_u.rd(SYS_CTRL_ADDR, v);
        chk("valid key", 8'h4B, v);
        @(posedge ref_clk_in);
        keypress_in <= 1'b0;
        wake(0);
    endtask
    task automatic t_soft();
        h_u.wr(SYS_CTRL_ADDR, 8'h4B);
        repeat (3) @(negedge ref_clk_in);
        chk("ext sel", 8'h01, {7'h00, ext_clk_sel_out});
        h_u.wr(SYS_CTRL_ADDR, 8'h8B);
        repeat (3) @(negedge ref_clk_in);
        chk("soft low", 8'h00, {7'h00, sys_reset_n_out});
        repeat (24) @(negedge ref_clk_in);
        chk("soft high", 8'h01, {7'h00, sys_reset_n_out});
        h_u.rd(SYS_CTRL_ADDR, v);
        chk("after soft", 8'h0B, v);
        @(posedge ref_clk_in);
        i2c_reset_req_in <= 1'b1;
        @(posedge ref_clk_in);
        i2c_reset_req_in <= 1'b0;
        @(negedge ref_clk_in);
        chk("i2c reset", 8'h00, {7'h00, sys_reset_n_out});
    endtask
    task automatic t_auto();
        logic [7:0] k;
        k = 8'h00;
        h_u.wr(SYS_CTRL_ADDR, 8'h4B);
        h_u.wr(SYS_CTRL_TWO_ADDR, 8'h08);
        h_u.xfer();
        repeat (600) begin
            @(negedge ref_clk_in);
            k += {7'h00, lf_tick_out};
        end
        chk("slow ticks", 8'h4B, k);
        chk("auto early", {6'h00, MODE_OPERATIONAL}, {6'h00, power_mode_out});
        wm(MODE_SLEEP);
    endtask
    task automatic complete_run();
        if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            num_errors++;
            complete_run();
        end
    end
    initial begin
        {reset_n_in, lvd_reset_in, rc_ready_in, wakeup_pin_in, keypress_in} = 5'h00;
        {hotkey_in, irq_event_in, i2c_reset_req_in} = 3'h0;
        {num_errors, cmp_count, cyc} = 0;
        repeat (10) @(posedge ref_clk_in);
        reset_n_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        t_regs();
        t_sleep();
        t_gates();
        t_hib();
        t_soft();
        t_auto();
        complete_run();
    end
endmodule // power_mode_controller_bench
bind pmc_power_mode_controller pmc_checker chk_u (.*);
